// ### design/gplp_defs.vh
// constants for the pin function configuration block
// assumes a 200 MHz system clock and one 32-bit configuration word
`ifndef GPLP_DEFS_VH
`define GPLP_DEFS_VH

// ==========================================
// register map
`define GPLP_CFG_OFFSET     8'h88
`define GPLP_CFG_RESET      32'h0000_0000
// writable bits: 30:28, 26:24, 22:20, 18:16, 10:8, 4:0
`define GPLP_CFG_WMASK      32'h7777_071f

// ==========================================
// field positions
`define GPLP_LED_LSB        28
`define GPLP_POL_LSB        24
`define GPLP_ROUTE_LSB      20
`define GPLP_BUF_LSB        16
`define GPLP_DIR_LSB        8
`define GPLP_OUTPUT_THREE_BIT       3
`define GPLP_OUTPUT_FOUR_BIT       4
`define GPLP_DATA_LSB       0

// ==========================================
// eeprom pin routing codes
`define GPLP_RT_EEPROM      3'h0
`define GPLP_RT_GPO34       3'h1
`define GPLP_RT_OUTPUT_THREE_RXDV   3'h3
`define GPLP_RT_TXEN_OUTPUT_FOUR   3'h5
`define GPLP_RT_TXEN_RXDV   3'h6
`define GPLP_RT_CLOCKS      3'h7

// ==========================================
// timing
`define GPLP_CLK_PERIOD_NS  5
`define GPLP_MIN_ACTIVE_NS  40
// least time rounds up to whole cycles
`define GPLP_MIN_ACTIVE_CYC \
	((`GPLP_MIN_ACTIVE_NS + `GPLP_CLK_PERIOD_NS - 1) / `GPLP_CLK_PERIOD_NS)

`endif

// ### design/gplp_sync.v
// two-flop synchroniser bank for the pin inputs
// assumes the inputs may change at any time relative to i_clk
`timescale 1ns/1ps

module gplp_sync #(
	parameter WIDTH = 4                   // number of synchronised bits
) (
	input  wire             i_clk,        // system clock
	input  wire             i_rst_n,      // synchronous reset, active low
	input  wire             i_ce,         // clock enable, freezes state when low
	input  wire [WIDTH-1:0] i_async,      // raw pin levels
	output reg  [WIDTH-1:0] o_sync        // levels safe to use in i_clk domain
);

	// ==========================================
	// first stage, read only by the second stage
	reg [WIDTH-1:0] meta_q;               // metastability catcher

	// two stages; one alone would let metastable levels reach the logic
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_q <= {WIDTH{1'b0}};
			o_sync <= {WIDTH{1'b0}};
		end else if (i_ce) begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule // gplp_sync

// ### design/gplp_top.v
// pin function configuration: three general i/o pins shared with led
// indicators, and two eeprom pins shared with general outputs and mii signals.
// assumes a register port from the host bus decoder and an interrupt
// enable register held elsewhere in the device.
//
// What this block does
// - led select bit turns pin into indicator
// - polarity bit picks the interrupt pin level
// - interrupt passes only when pin enable set
// - route field picks eeprom pin functions
// - drive type bit: push-pull or open-drain
// - direction bit: one output, zero input
// - bits four and three drive general outputs
// - data bits drive outputs, read live pins
`timescale 1ns/1ps
`include "gplp_defs.vh"

module gplp_top #(
	parameter NPIN = 3,                   // general i/o pin count
	parameter CW   = 4                    // width of the qualify counter
) (
	input  wire            i_clk,         // system clock, 200 MHz
	input  wire            i_rst_n,       // synchronous reset, active low
	input  wire            i_ce,          // clock enable, freezes state when low
	input  wire [7:0]      i_reg_addr,    // register byte offset
	input  wire            i_reg_wr,      // write strobe
	input  wire            i_reg_rd,      // read strobe
	input  wire [31:0]     i_reg_wdata,   // write data
	output reg  [31:0]     o_reg_rdata,   // read data, one cycle after strobe
	output reg             o_reg_rvalid,  // read data valid pulse
	input  wire [NPIN-1:0] i_pin_irq_enable, // per-pin interrupt enables
	input  wire [NPIN-1:0] i_led_state,   // internal led indicator levels
	output reg  [NPIN-1:0] o_irq_set,     // sets interrupt status bits
	input  wire [NPIN-1:0] i_pin_in,      // general i/o pin levels
	output reg  [NPIN-1:0] o_pin_out,     // general i/o pin output value
	output reg  [NPIN-1:0] o_pin_oe,      // general i/o pin drive enable
	input  wire            i_ee_data_out, // eeprom controller data to pin
	input  wire            i_ee_data_oe,  // eeprom controller drives data
	input  wire            i_ee_clk,      // eeprom controller serial clock
	output reg             o_ee_data_in,  // data pin level to eeprom controller
	input  wire            i_tx_en,       // mii transmit enable
	input  wire            i_rx_dv,       // mii receive data valid
	input  wire            i_tx_clk,      // mii transmit clock level
	input  wire            i_rx_clk,      // mii receive clock level
	input  wire            i_eeprom_data_pin_in, // data pin level
	output reg             o_eeprom_data_pin_out, // data pin output value
	output reg             o_eeprom_data_pin_oe,  // data pin drive enable
	output reg             o_eeprom_clock_pin,    // clock pin level
	output reg             o_eeprom_clock_pin_oe  // clock pin drive enable
);

	// ==========================================
	// configuration register
	reg  [31:0] cfg_q;                    // pin_function_config storage
	reg  [31:0] cfg_d;                    // next value

	wire        cfg_hit;                  // address matches the register
	assign cfg_hit = (i_reg_addr == `GPLP_CFG_OFFSET);

	// field views
	wire [NPIN-1:0] indicator_select;      // led mode per pin
	wire [NPIN-1:0] pin_irq_level_polarity; // active interrupt level
	wire [2:0]      eeprom_pin_route;      // eeprom pin function
	wire [NPIN-1:0] pin_drive_type;        // one push-pull, zero open-drain
	wire [NPIN-1:0] pin_direction;         // one output
	wire [NPIN-1:0] pin_value;             // written output value
	wire            output_three;          // general output three value
	wire            output_four;           // general output four value

	assign indicator_select       = cfg_q[`GPLP_LED_LSB +: NPIN];
	assign pin_irq_level_polarity = cfg_q[`GPLP_POL_LSB +: NPIN];
	assign eeprom_pin_route       = cfg_q[`GPLP_ROUTE_LSB +: 3];
	assign pin_drive_type         = cfg_q[`GPLP_BUF_LSB +: NPIN];
	assign pin_direction          = cfg_q[`GPLP_DIR_LSB +: NPIN];
	assign pin_value              = cfg_q[`GPLP_DATA_LSB +: NPIN];
	assign output_three           = cfg_q[`GPLP_OUTPUT_THREE_BIT];
	assign output_four            = cfg_q[`GPLP_OUTPUT_FOUR_BIT];

	// write merge; reserved bits never take write data
	always @* begin
		cfg_d = cfg_q;
		if (i_reg_wr && cfg_hit) begin
			cfg_d = i_reg_wdata & `GPLP_CFG_WMASK;
		end
	end

	// storage, cleared at reset
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			cfg_q <= `GPLP_CFG_RESET;
		end else if (i_ce) begin
			cfg_q <= cfg_d;
		end
	end

	// ==========================================
	// pin input synchronisers
	wire [NPIN:0] sync_lvl;               // synced pins, top bit eeprom data
	wire [NPIN-1:0] pin_lvl;              // synced general pin levels

	gplp_sync #(
		.WIDTH   (NPIN + 1)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_async ({i_eeprom_data_pin_in, i_pin_in}),
		.o_sync  (sync_lvl)
	);

	assign pin_lvl = sync_lvl[NPIN-1:0];

	// ==========================================
	// register read port
	// data pin bits show the live synced pin, not the written value
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_reg_rdata  <= 32'h0000_0000;
			o_reg_rvalid <= 1'b0;
		end else if (i_ce) begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd && cfg_hit) begin
				o_reg_rdata <= (cfg_q & ~{{(32-NPIN){1'b0}}, {NPIN{1'b1}}})
					| {{(32-NPIN){1'b0}}, pin_lvl};
			end else begin
				o_reg_rdata <= 32'h0000_0000; // unmapped offsets read zero
			end
		end
	end

	// ==========================================
	// per-pin drive and interrupt qualification
	localparam integer  QUAL_INT = `GPLP_MIN_ACTIVE_CYC; // 40 ns in cycles
	localparam [CW-1:0] QUAL_CYC = QUAL_INT[CW-1:0];    // cut to counter width

	wire [NPIN-1:0] irq_d;                // next interrupt set levels
	wire [NPIN-1:0] pout_d;               // next pin output values
	wire [NPIN-1:0] poe_d;                // next pin drive enables

	genvar g;
	generate
		for (g = 0; g < NPIN; g = g + 1) begin : g_pin
			reg  [CW-1:0] hold_q;          // cycles the active level has held
			wire          active;          // pin at its interrupt level
			wire          drv_val;         // value the pin should show
			wire          drv_out;         // pin is an output at all

			// high level counts when polarity is one, low when zero
			assign active  = (pin_lvl[g] == pin_irq_level_polarity[g]);
			// indicator mode overrides general i/o
			assign drv_val = indicator_select[g] ? i_led_state[g]
				: pin_value[g];
			assign drv_out = indicator_select[g] | pin_direction[g];

			// qualify counter; the source must hold the level long enough,
			// so glitches shorter than this are filtered out
			always @(posedge i_clk) begin
				if (!i_rst_n) begin
					hold_q <= {CW{1'b0}};
				end else if (i_ce) begin
					if (!active) begin
						hold_q <= {CW{1'b0}};
					end else if (hold_q != QUAL_CYC) begin
						hold_q <= hold_q + {{(CW-1){1'b0}}, 1'b1};
					end
				end
			end

			// level interrupt toward status, only when enabled
			assign irq_d[g] = (hold_q == QUAL_CYC) & i_pin_irq_enable[g];

			// output buffer; open-drain only pulls low, never drives high,
			// and an input pin is released with its value held at zero
			assign pout_d[g] = drv_out & pin_drive_type[g] & drv_val;
			assign poe_d[g]  = drv_out & (pin_drive_type[g] | ~drv_val);
		end
	endgenerate

	// one process owns all general i/o pin flops, so no vector has several drivers
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_irq_set <= {NPIN{1'b0}};
			o_pin_out <= {NPIN{1'b0}};
			o_pin_oe  <= {NPIN{1'b0}};
		end else if (i_ce) begin
			o_irq_set <= irq_d;
			o_pin_out <= pout_d;
			o_pin_oe  <= poe_d;
		end
	end

	// ==========================================
	// eeprom pin routing
	// every function passes through one flop; mii clocks therefore carry
	// up to one system cycle of skew and must be well below 100 MHz
	reg ee_dat_d;                         // data pin next value
	reg ee_doe_d;                         // data pin next enable
	reg ee_clk_d;                         // clock pin next value
	reg ee_coe_d;                         // clock pin next enable

	always @* begin
		ee_dat_d = 1'b0;
		ee_doe_d = 1'b0;
		ee_clk_d = 1'b0;
		ee_coe_d = 1'b1;
		case (eeprom_pin_route)
			`GPLP_RT_EEPROM: begin
				ee_dat_d = i_ee_data_out;
				ee_doe_d = i_ee_data_oe;
				ee_clk_d = i_ee_clk;
			end
			`GPLP_RT_GPO34: begin
				ee_dat_d = output_three;
				ee_doe_d = 1'b1;
				ee_clk_d = output_four;
			end
			`GPLP_RT_OUTPUT_THREE_RXDV: begin
				ee_dat_d = output_three;
				ee_doe_d = 1'b1;
				ee_clk_d = i_rx_dv;
			end
			`GPLP_RT_TXEN_OUTPUT_FOUR: begin
				ee_dat_d = i_tx_en;
				ee_doe_d = 1'b1;
				ee_clk_d = output_four;
			end
			`GPLP_RT_TXEN_RXDV: begin
				ee_dat_d = i_tx_en;
				ee_doe_d = 1'b1;
				ee_clk_d = i_rx_dv;
			end
			`GPLP_RT_CLOCKS: begin
				ee_dat_d = i_tx_clk;
				ee_doe_d = 1'b1;
				ee_clk_d = i_rx_clk;
			end
			default: begin
				// unused codes release both pins
				ee_dat_d = 1'b0;
				ee_doe_d = 1'b0;
				ee_clk_d = 1'b0;
				ee_coe_d = 1'b0;
			end
		endcase
	end

	// pin flops; a mid-cycle route change would corrupt an eeprom transfer,
	// software keeps the route steady while one runs
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_eeprom_data_pin_out <= 1'b0;
			o_eeprom_data_pin_oe  <= 1'b0;
			o_eeprom_clock_pin    <= 1'b0;
			o_eeprom_clock_pin_oe <= 1'b0;
			o_ee_data_in          <= 1'b0;
		end else if (i_ce) begin
			o_eeprom_data_pin_out <= ee_dat_d;
			o_eeprom_data_pin_oe  <= ee_doe_d;
			o_eeprom_clock_pin    <= ee_clk_d;
			o_eeprom_clock_pin_oe <= ee_coe_d;
			o_ee_data_in          <= sync_lvl[NPIN];
		end
	end

endmodule // gplp_top

// ### sim/gplp_pins_model.sv
// far side of the pins: external gpio sources and eeprom pull-up
// assumes a released pin follows the external source level
`timescale 1ns/1ps
module gplp_pins_model (
	input  wire [2:0] i_pin_out,          // device value
	input  wire [2:0] i_pin_oe,           // device enable
	input  wire [2:0] i_ext,              // external source level
	input  wire       i_ee_out,           // device data value
	input  wire       i_ee_oe,            // device data enable
	output wire [2:0] o_pin_lvl,          // wire level
	output wire       o_ee_lvl            // data wire level
);
	// device wins while it drives; open-drain high lets the source show
	assign o_pin_lvl = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
	// pull-up on a released eeprom data line
	assign o_ee_lvl  = i_ee_oe ? i_ee_out : 1'b1;
endmodule // gplp_pins_model

// ### sim/gplp_top_assertions.sv
// checker for the pin function block, bound into gplp_top
// assumes the bench may drop i_ce; rules are skipped while it is low
`timescale 1ns/1ps
module gplp_top_assertions #(
	parameter NPIN = 3                    // pin count
) (
	input wire            i_clk,          // clock
	input wire            i_rst_n,        // reset, active low
	input wire            i_ce,           // clock enable
	input wire [7:0]      i_reg_addr,     // offset
	input wire            i_reg_wr,       // write
	input wire            i_reg_rd,       // read
	input wire [31:0]     i_reg_wdata,    // write data
	input wire [31:0]     o_reg_rdata,    // read data
	input wire            o_reg_rvalid,   // read valid
	input wire [NPIN-1:0] i_pin_irq_enable, // enables
	input wire [NPIN-1:0] i_led_state,    // led levels
	input wire [NPIN-1:0] o_irq_set,      // irq out
	input wire [NPIN-1:0] i_pin_in,       // pin levels
	input wire [NPIN-1:0] o_pin_out,      // pin value
	input wire [NPIN-1:0] o_pin_oe,       // pin enable
	input wire            i_ee_data_out,  // ctrl data
	input wire            i_ee_data_oe,   // ctrl enable
	input wire            i_ee_clk,       // ctrl clock
	input wire            i_tx_en,        // mii
	input wire            i_rx_dv,        // mii
	input wire            i_tx_clk,       // mii
	input wire            i_rx_clk,       // mii
	input wire            o_eeprom_data_pin_out, // data pin
	input wire            o_eeprom_data_pin_oe,  // data enable
	input wire            o_eeprom_clock_pin,    // clock pin
	input wire            o_eeprom_clock_pin_oe, // clock enable
	input wire            i_eeprom_data_pin_in,  // data pin level
	input wire            o_ee_data_in           // data level to controller
);
	// ==========================================
	// shadow config and expected pin drive
	reg  [31:0]     cfg_q;                // masked copy of the config word
	reg  [NPIN-1:0] x_oe, x_out;          // expected gpio drive
	reg             eo, ed, co, cl, v;    // expected eeprom pins
	integer         i;
	wire            act0 = i_pin_in[0] == cfg_q[24]; // pin 0 at its irq level
	reg  [1:0]      run_cnt;              // running edges since reset or freeze
	// data pin path is three flops deep; skip until it has refilled
	always @(posedge i_clk)
		if (!i_rst_n || !i_ce) run_cnt <= 2'h0;
		else if (run_cnt != 2'h3) run_cnt <= run_cnt + 2'h1;
	// shadow follows host writes, reserved bits dropped
	always @(posedge i_clk)
		if (!i_rst_n) cfg_q <= 32'h0;
		else if (i_ce && i_reg_wr && i_reg_addr == 8'h88) cfg_q <= i_reg_wdata & 32'h7777_071f;
	// led or output drives; open-drain only pulls low
	always @* begin
		for (i = 0; i < NPIN; i = i + 1) begin
			v = cfg_q[28+i] ? i_led_state[i] : cfg_q[i];
			if (!(cfg_q[28+i] | cfg_q[8+i])) {x_oe[i], x_out[i]} = 2'h0;
			else if (cfg_q[16+i]) {x_oe[i], x_out[i]} = {1'b1, v};
			else {x_oe[i], x_out[i]} = {~v, 1'b0};
		end
	end
	// reserved route codes release both pins
	always @*
		case (cfg_q[22:20])
			3'h0: {eo, ed, co, cl} = {i_ee_data_oe, i_ee_data_out, 1'b1, i_ee_clk};
			3'h1: {eo, ed, co, cl} = {1'b1, cfg_q[3], 1'b1, cfg_q[4]};
			3'h3: {eo, ed, co, cl} = {1'b1, cfg_q[3], 1'b1, i_rx_dv};
			3'h5: {eo, ed, co, cl} = {1'b1, i_tx_en, 1'b1, cfg_q[4]};
			3'h6: {eo, ed, co, cl} = {1'b1, i_tx_en, 1'b1, i_rx_dv};
			3'h7: {eo, ed, co, cl} = {1'b1, i_tx_clk, 1'b1, i_rx_clk};
			default: {eo, ed, co, cl} = 4'h0;
		endcase
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n || !i_ce);
	// ==========================================
	// properties
	property p_rd_cfg;
		i_reg_rd && i_reg_addr == 8'h88 |=> o_reg_rvalid && o_reg_rdata[31:3] == $past(cfg_q[31:3]);
	endproperty
	a_rd_cfg: assert property (p_rd_cfg)
		else $error("config read wrong");
	property p_rd_other;
		i_reg_rd && i_reg_addr != 8'h88 |=> o_reg_rdata == 32'h0;
	endproperty
	a_rd_other: assert property (p_rd_other)
		else $error("unmapped read not zero");
	property p_pin_rd;
		$stable(i_pin_in)[*4] ##0 (i_reg_rd && i_reg_addr == 8'h88) |=> o_reg_rdata[2:0] == $past(i_pin_in[2:0]);
	endproperty
	a_pin_rd: assert property (p_pin_rd)
		else $error("pin readback wrong");
	property p_irq_q;
		$rose(o_irq_set[0]) |-> $past(act0, 3) && $past(act0, 7);
	endproperty
	a_irq_q: assert property (p_irq_q)
		else $error("irq without held level");
	property p_irq_en;
		o_irq_set != 0 |-> (o_irq_set & ~$past(i_pin_irq_enable)) == 0;
	endproperty
	a_irq_en: assert property (p_irq_en)
		else $error("irq on disabled pin");
	property p_pin_oe;
		1'b1 |=> o_pin_oe == $past(x_oe);
	endproperty
	a_pin_oe: assert property (p_pin_oe)
		else $error("pin enable wrong");
	property p_pin_out;
		1'b1 |=> o_pin_out == $past(x_out);
	endproperty
	a_pin_out: assert property (p_pin_out)
		else $error("pin value wrong");
	property p_rt_oe;
		1'b1 |=> {o_eeprom_data_pin_oe, o_eeprom_clock_pin_oe} == $past({eo, co});
	endproperty
	a_rt_oe: assert property (p_rt_oe)
		else $error("route enables wrong");
	property p_rt_lvl;
		co |=> o_eeprom_clock_pin == $past(cl) && (!$past(eo) || o_eeprom_data_pin_out == $past(ed));
	endproperty
	a_rt_lvl: assert property (p_rt_lvl)
		else $error("route levels wrong");
	property p_ee_in;
		run_cnt == 2'h3 |-> o_ee_data_in == $past(i_eeprom_data_pin_in, 3);
	endproperty
	a_ee_in: assert property (p_ee_in)
		else $error("eeprom data level wrong");
endmodule // gplp_top_assertions
bind gplp_top gplp_top_assertions #(.NPIN(NPIN)) u_chk (.*);

// ### sim/gplp_top_tb.sv
// self-checking bench for gplp_top with pin model
// assumes inputs change at the falling edge
`timescale 1ns/1ps
module gplp_top_tb;
	logic i_clk = 0, i_rst_n = 0, i_ce = 1, i_reg_wr = 0, i_reg_rd = 0, o_reg_rvalid;
	logic [7:0] i_reg_addr = 8'h0;
	logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, cfg = 32'h0, q[$];
	logic [2:0] i_pin_irq_enable = 3'h1, i_led_state = 3'h0, o_irq_set, i_pin_in, o_pin_out;
	logic [2:0] o_pin_oe, ext = 3'h7, rts[8] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7, 3'h1, 3'h0};
	logic i_ee_data_out = 0, i_ee_data_oe = 0, i_ee_clk = 0, o_ee_data_in, i_tx_en = 0;
	logic i_rx_dv = 0, i_tx_clk = 0, i_rx_clk = 0, i_eeprom_data_pin_in, o_eeprom_data_pin_out;
	logic o_eeprom_data_pin_oe, o_eeprom_clock_pin, o_eeprom_clock_pin_oe;
	int err_total = 0, n_compared = 0, cyc = 0;
	gplp_top dut (.*);
	gplp_pins_model pm (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_ext(ext),
		.i_ee_out(o_eeprom_data_pin_out), .i_ee_oe(o_eeprom_data_pin_oe),
		.o_pin_lvl(i_pin_in), .o_ee_lvl(i_eeprom_data_pin_in));
	initial forever #2.5 i_clk = ~i_clk;
	// ==========================================
	// helpers
	task end_sim;
		$display("errors %0d compares %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	// expected pin level: device drive, else the external source
	function automatic logic [2:0] lvl();
		logic [2:0] r;
		for (int i = 0; i < 3; i++) begin
			logic vv;
			vv = cfg[28+i] ? i_led_state[i] : cfg[i];
			r[i] = !(cfg[28+i] | cfg[8+i]) ? ext[i] : cfg[16+i] ? vv : (vv & ext[i]);
		end
		return r;
	endfunction
	// one register cycle; a read notes the old word, as the port returns it
	task acc(input logic [7:0] a, input logic [31:0] d, input logic w, input logic r);
		@(negedge i_clk);
		{i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd} = {a, d, w, r};
		if (r) q.push_back(a == 8'h88 ? {cfg[31:3], lvl()} : 32'h0);
		if (w && a == 8'h88) cfg = d & 32'h7777_071f;
		@(negedge i_clk);
		{i_reg_wr, i_reg_rd} = 2'h0;
	endtask
	// toggle pin 0 for n cycles and watch the irq line
	task pulse(input int n, input logic e);
		logic s;
		s = 0;
		ext[0] = ~ext[0];
		for (int k = 0; k < n + 14; k++) begin
			@(negedge i_clk);
			if (k == n - 1) ext[0] = ~ext[0];
			s = s | o_irq_set[0];
		end
		chk("irq0", {31'h0, e}, {31'h0, s});
	endtask
	// ==========================================
	// result watcher, random mii/eeprom traffic, hang guard
	always @(negedge i_clk)
		if (o_reg_rvalid === 1'b1) chk("rdata", q.size() ? q.pop_front() : 32'hdead_beef, o_reg_rdata);
	always @(negedge i_clk)
		if (i_rst_n) {i_tx_en, i_rx_dv, i_tx_clk, i_rx_clk, i_ee_data_out, i_ee_data_oe, i_ee_clk} <= 7'($urandom);
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_sim;
		end
	end
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(53));
		repeat (20) @(negedge i_clk);
		i_rst_n = 1;
		repeat (3) @(negedge i_clk); // synchronisers refill after reset
		acc(8'h88, 32'h0, 0, 1);
		pulse(5, 0);
		pulse(20, 1);
		i_pin_irq_enable = 3'h0;
		pulse(20, 0);
		i_pin_irq_enable = 3'h1;
		ext = 3'h0;
		acc(8'h88, 32'h0100_0000, 1, 0);
		pulse(20, 1);
		for (int j = 0; j < 10; j++) begin
			ext = 3'($urandom);
			i_led_state = 3'($urandom);
			acc(8'h88, $urandom & 32'hff8f_ffff, 1, 0);
			repeat (6) @(negedge i_clk);
			acc(8'h88, 32'h0, 0, 1);
			acc(8'h8c, $urandom, 1, 1);
		end
		acc(8'h88, 32'hffff_ffff, 1, 1);
		repeat (6) @(negedge i_clk);
		acc(8'h88, 32'h0, 0, 1);
		// mid-run reset from a full word, then a write while frozen
		i_rst_n = 0;
		repeat (3) @(negedge i_clk);
		i_ce = 0;
		i_rst_n = 1;
		acc(8'h88, 32'h0000_0700, 1, 0);
		cfg = 32'h0; // frozen write must not land
		i_ce = 1;
		repeat (3) @(negedge i_clk);
		acc(8'h88, 32'h0, 0, 1);
		// only legal route codes; no eeprom transfer is modelled meanwhile
		for (int j = 0; j < 8; j++) begin
			acc(8'h88, {9'h0, rts[j], 15'h0, 2'($urandom), 3'h0}, 1, 0);
			repeat (10) @(negedge i_clk);
		end
		end_sim;
	end
endmodule // gplp_top_tb
